// ==== host_pwr_end.sv ====
// Host end: runs the software-controlled module power-up over the link.
`timescale 1ns/1ns
module host_pwr_end (
	input  wire logic                      mclk_i,        // Clock.
	input  wire logic                      nrst_i,        // Async reset, active low.
	input  wire module_pwr_pkg::av_addr_t  address_i,     // Avalon word address.
	input  wire logic                      read_i,        // Avalon read.
	input  wire logic                      write_i,       // Avalon write.
	input  wire logic [31:0]               writedata_i,   // Avalon write data.
	output logic [31:0]                    readdata_o,    // Avalon read data.
	output logic                           waitrequest_o, // Avalon wait request.
	mgmt_link_if.host_end                  link           // Link to module.
);
	import module_pwr_pkg::*;

	// ********************************************************************
	// State.
	// ********************************************************************
	typedef struct packed {
		host_state_e st;
		logic        pin_off;
		byte_t       limit;
		byte_t       power;
		byte_t       flags_seen;
		logic        mod_reset_n;
		logic        hw_pin;
		logic        sel;
		logic        req;
		logic        we;
		byte_t       addr;
		byte_t       wdata;
		logic [31:0] readdata;
		logic        waitrequest;
	} host_s;

	host_s s;
	host_s next_s;

	logic  op;
	logic  op_we;
	byte_t op_addr;
	byte_t op_wdata;

	always_comb begin
		next_s   = s;
		op       = 1'b0;
		op_we    = 1'b0;
		op_addr  = BYTE_ZERO;
		op_wdata = BYTE_ZERO;

		// Avalon slave: one wait cycle, then the answer edge.
		next_s.waitrequest = ~((read_i | write_i) & s.waitrequest);
		if (read_i & s.waitrequest) begin
			case (address_i)
				AV_STATUS: next_s.readdata = {24'h000000, link.irq, 3'h0, 4'(s.st)};
				AV_LIMIT:  next_s.readdata = {24'h000000, s.limit};
				AV_POWER:  next_s.readdata = {24'h000000, s.power};
				default: begin
					next_s.readdata                   = '0;
					next_s.readdata[CTRL_PIN_OFF_BIT] = s.pin_off;
				end
			endcase
		end
		if (write_i & ~s.waitrequest) begin
			if (address_i == AV_CTRL) begin
				next_s.pin_off = writedata_i[CTRL_PIN_OFF_BIT];
				if (writedata_i[CTRL_START_BIT] &&
				    (s.st == h_idle || s.st == h_done || s.st == h_fault)) begin
					// Pins go up while the module is held in reset, so a restart reinitialises it.
					next_s.st          = h_wait_present;
					next_s.mod_reset_n = 1'b0;
					next_s.hw_pin      = 1'b1;
					next_s.sel         = 1'b1;
				end
			end else if (address_i == AV_LIMIT) begin
				next_s.limit = writedata_i[7:0];
			end
		end

		// Sequence.
		case (s.st)
			h_idle: begin
				next_s.mod_reset_n = 1'b0;
			end
			h_wait_present: begin
				if (link.present) begin
					next_s.mod_reset_n = 1'b1;
					next_s.st          = h_wait_irq1;
				end
			end
			h_wait_irq1: begin
				if (link.irq) begin
					next_s.st = h_read_flag1;
				end
			end
			h_read_flag1: begin
				op      = 1'b1;
				op_addr = REG_FLAGS;
			end
			h_read_power: begin
				op      = 1'b1;
				op_addr = REG_POWER_CLASS;
			end
			h_write_hold: begin
				op       = 1'b1;
				op_we    = 1'b1;
				op_addr  = REG_HOLD;
				op_wdata = ALL_ONES;
			end
			h_write_tx_off: begin
				op       = 1'b1;
				op_we    = 1'b1;
				op_addr  = REG_TX_OFF;
				op_wdata = ALL_ONES;
			end
			h_write_pctl: begin
				op       = 1'b1;
				op_we    = 1'b1;
				op_addr  = REG_POWER_CTRL;
				op_wdata = PCTL_HOST_GO;
			end
			h_wait_irq2: begin
				if (link.irq) begin
					next_s.st = h_read_flag2;
				end
			end
			h_read_flag2: begin
				op      = 1'b1;
				op_addr = REG_FLAGS;
			end
			h_done, h_fault: begin
			end
			default: next_s.st = h_idle;
		endcase

		// One management access per state; advance on its acknowledge.
		if (op) begin
			if (!s.req) begin
				next_s.req   = 1'b1;
				next_s.we    = op_we;
				next_s.addr  = op_addr;
				next_s.wdata = op_wdata;
			end else if (link.ack) begin
				next_s.req = 1'b0;
				case (s.st)
					h_read_flag1: begin
						next_s.flags_seen = link.rdata;
						next_s.st         = h_read_power;
					end
					h_read_power: begin
						next_s.power = link.rdata;
						next_s.st    = (link.rdata > s.limit) ? h_fault : h_write_hold;
					end
					h_write_hold:   next_s.st = h_write_tx_off;
					h_write_tx_off: next_s.st = h_write_pctl;
					h_write_pctl: begin
						next_s.st = h_wait_irq2;
						if (s.pin_off) begin
							next_s.hw_pin = 1'b0;
						end
					end
					default: begin
						next_s.flags_seen = link.rdata;
						next_s.st         = h_done;
					end
				endcase
			end
		end
	end

	always_ff @(posedge mclk_i or negedge nrst_i) begin
		if (!nrst_i) begin
			s <= '{st: h_idle, limit: LIMIT_DEF, waitrequest: 1'b1, default: '0};
		end else begin
			s <= next_s;
		end
	end

	assign readdata_o                = s.readdata;
	assign waitrequest_o             = s.waitrequest;
	assign link.mod_reset_n          = s.mod_reset_n;
	assign link.hw_power_down_request_pin = s.hw_pin;
	assign link.module_select_pin    = s.sel;
	assign link.req                  = s.req;
	assign link.we                   = s.we;
	assign link.addr                 = s.addr;
	assign link.wdata                = s.wdata;

endmodule : host_pwr_end

// ==== mgmt_link_if.sv ====
// Pins and byte-wide management access between host and module.
`timescale 1ns/1ns
interface mgmt_link_if;
	logic       mod_reset_n;
	logic       hw_power_down_request_pin;
	logic       module_select_pin;
	logic       req;
	logic       we;
	logic [7:0] addr;
	logic [7:0] wdata;
	logic       present;
	logic       irq;
	logic       ack;
	logic [7:0] rdata;

	modport host_end (
		output mod_reset_n, hw_power_down_request_pin, module_select_pin,
		output req, we, addr, wdata,
		input  present, irq, ack, rdata
	);

	modport module_end (
		input  mod_reset_n, hw_power_down_request_pin, module_select_pin,
		input  req, we, addr, wdata,
		output present, irq, ack, rdata
	);
endinterface : mgmt_link_if

// ==== module_pwr_assertions.sv ====
// Checker for the management link between host end and module end.
`timescale 1ns/1ns
module module_pwr_assertions (
	input wire logic       mclk_i,                    // Clock.
	input wire logic       nrst_i,                    // Async reset, active low.
	input wire logic       mod_reset_n,               // Module reset pin.
	input wire logic       hw_power_down_request_pin, // Hardware power-down request.
	input wire logic       module_select_pin,         // Module select.
	input wire logic       req,                       // Access request.
	input wire logic       we,                        // Write access.
	input wire logic [7:0] addr,                      // Register offset.
	input wire logic [7:0] wdata,                     // Write data.
	input wire logic       irq,                       // Module interrupt.
	input wire logic       ack                        // Access acknowledge.
);
	import module_pwr_pkg::*;

	// ********************************************************************
	// Helper state.
	// ********************************************************************
	logic seen_irq;
	logic hold_ff;
	logic txoff_ff;
	logic class_rd;
	logic touch_q;
	logic touch_now;

	// Apart from a module reset, a flag read or a mask write is the only legal reason for the interrupt to drop.
	assign touch_now = ack && ((!we && addr == REG_FLAGS) || (we && addr == REG_MASK));

	always_ff @(posedge mclk_i or negedge nrst_i) begin
		if (!nrst_i || !mod_reset_n) begin
			seen_irq <= 1'b0;
			hold_ff  <= 1'b0;
			txoff_ff <= 1'b0;
			class_rd <= 1'b0;
			touch_q  <= 1'b0;
		end else begin
			seen_irq <= seen_irq | irq;
			touch_q  <= touch_now;
			if (ack && we && addr == REG_HOLD) begin
				hold_ff <= (wdata == ALL_ONES);
			end
			if (ack && we && addr == REG_TX_OFF) begin
				txoff_ff <= (wdata == ALL_ONES);
			end
			if (ack && !we && addr == REG_POWER_CLASS) begin
				class_rd <= 1'b1;
			end
		end
	end

	default clocking cb @(posedge mclk_i); endclocking
	default disable iff (!nrst_i);

	// ********************************************************************
	// Assertions.
	// ********************************************************************
	a_reset_pin_order: assert property ($rose(mod_reset_n) |->
		hw_power_down_request_pin && module_select_pin)
		else $error("module reset released without request and select pins high");
	a_req_after_irq: assert property (req |-> seen_irq)
		else $error("access before the first interrupt");
	a_init_irq: assert property ($rose(mod_reset_n) |-> ##[1:40] irq)
		else $error("no interrupt after module initialisation");
	a_flag_read_clears: assert property (ack && !we && addr == REG_FLAGS |-> ##[0:2] !irq)
		else $error("interrupt stays after flag read");
	a_irq_fall_cause: assert property ($fell(irq) |->
		touch_now || touch_q || !mod_reset_n || !$past(mod_reset_n))
		else $error("interrupt dropped while flag still set");
	a_ctrl_write_order: assert property (req && we && addr == REG_POWER_CTRL |->
		class_rd && hold_ff && txoff_ff && wdata == PCTL_HOST_GO)
		else $error("power control written out of order or with wrong value");
	a_powerup_irq: assert property (ack && we && addr == REG_POWER_CTRL |-> ##[1:80] irq)
		else $error("no interrupt after power-up request");
	a_ack_one_pulse: assert property (ack |=> !ack && !req)
		else $error("ack longer than one cycle or request not dropped");
	a_ack_has_req: assert property ($rose(ack) |-> $past(req) && $past(module_select_pin))
		else $error("ack without a selected request");
	a_req_held: assert property (req && !ack |=>
		req && $stable(addr) && $stable(we) && $stable(wdata))
		else $error("request changed before ack");

	c_ctrl_write: cover property (ack && we && addr == REG_POWER_CTRL);
	c_irq_drop: cover property ($fell(irq));
	c_mod_start: cover property ($rose(mod_reset_n));
endmodule : module_pwr_assertions

// ==== module_pwr_end.sv ====
// Module end: management registers and module power state machine.
`timescale 1ns/1ns
module module_pwr_end #(
	parameter module_pwr_pkg::byte_t DEFAULT_CFG = 8'h11 // Power-on data path configuration.
) (
	input  wire logic                          mclk_i,          // Clock.
	input  wire logic                          nrst_i,          // Async reset, active low.
	mgmt_link_if.module_end                    link,            // Link to host.
	input  wire logic [7:0]                    power_class_i,   // Advertised power need.
	output module_pwr_pkg::module_state_e      module_state_o,  // Module state.
	output logic                               high_power_o,    // High power enabled.
	output logic [7:0]                         active_cfg_o,    // Active configuration.
	output logic [7:0]                         datapath_hold_o, // Data path hold mask.
	output logic [7:0]                         tx_off_o,        // Transmit off mask.
	output logic [7:0]                         tx_mute_o        // Transmit mute mask.
);
	import module_pwr_pkg::*;

	// ********************************************************************
	// State.
	// ********************************************************************
	typedef struct packed {
		module_state_e st;
		cnt_t          cnt;
		byte_t         flags;
		byte_t         mask;
		logic          sw_power_down_request;
		logic          hw_power_down_allow;
		logic          hw_pin_ignore;
		byte_t         datapath_hold_mask;
		byte_t         tx_output_off_mask;
		byte_t         tx_forced_mute_mask;
		byte_t         active_cfg;
		byte_t         staged_cfg0;
		logic          present;
		logic          irq;
		logic          ack;
		logic          high_power;
		byte_t         rdata;
	} dev_s;

	dev_s s;
	dev_s next_s;

	// ********************************************************************
	// Helpers.
	// ********************************************************************
	function automatic dev_s init_defaults(input dev_s cur);
		dev_s d;
		d                       = cur;
		d.st                    = management_init_state;
		d.cnt                   = MGMT_INIT_LOAD;
		d.flags                 = BYTE_ZERO;
		d.mask                  = BYTE_ZERO;
		d.sw_power_down_request = 1'b0;
		d.hw_power_down_allow   = 1'b1;
		d.hw_pin_ignore         = 1'b0;
		d.datapath_hold_mask    = BYTE_ZERO;
		d.tx_output_off_mask    = BYTE_ZERO;
		d.tx_forced_mute_mask   = BYTE_ZERO;
		d.active_cfg            = DEFAULT_CFG;
		d.staged_cfg0           = DEFAULT_CFG;
		d.irq                   = 1'b0;
		d.ack                   = 1'b0;
		d.rdata                 = BYTE_ZERO;
		return d;
	endfunction : init_defaults

	function automatic byte_t read_reg(input dev_s cur, input byte_t a, input byte_t pclass);
		byte_t r;
		r = BYTE_ZERO;
		case (a)
			REG_FLAGS:       r = cur.flags;
			REG_MASK:        r = cur.mask;
			REG_MOD_STATE:   r = 8'(cur.st);
			REG_POWER_CTRL: begin
				r[PCTL_SW_REQ_BIT] = cur.sw_power_down_request;
				r[PCTL_ALLOW_BIT]  = cur.hw_power_down_allow;
				r[PCTL_IGNORE_BIT] = cur.hw_pin_ignore;
			end
			REG_POWER_CLASS: r = pclass;
			REG_HOLD:        r = cur.datapath_hold_mask;
			REG_TX_OFF:      r = cur.tx_output_off_mask;
			REG_TX_MUTE:     r = cur.tx_forced_mute_mask;
			REG_DP_STATE:    r = DP_OFF_CODE;
			REG_ACTIVE_CFG:  r = cur.active_cfg;
			REG_STAGED_CFG0: r = cur.staged_cfg0;
			default:         r = BYTE_ZERO;
		endcase
		return r;
	endfunction : read_reg

	// ********************************************************************
	// Next state.
	// ********************************************************************
	logic  combined_power_down_condition;
	logic  access;
	byte_t flag_set;
	byte_t flag_clr;

	always_comb begin
		next_s   = s;
		flag_set = BYTE_ZERO;
		flag_clr = BYTE_ZERO;
		combined_power_down_condition = s.sw_power_down_request |
			(s.hw_power_down_allow & link.hw_power_down_request_pin & ~s.hw_pin_ignore);
		access = link.req & ~s.ack & link.module_select_pin &
			(s.st != management_init_state);

		next_s.present = 1'b1;
		next_s.ack     = access;

		// Register access; a flag read clears what was read.
		if (access) begin
			if (link.we) begin
				case (link.addr)
					REG_MASK: next_s.mask = link.wdata;
					REG_POWER_CTRL: begin
						next_s.sw_power_down_request = link.wdata[PCTL_SW_REQ_BIT];
						next_s.hw_power_down_allow   = link.wdata[PCTL_ALLOW_BIT];
						next_s.hw_pin_ignore         = link.wdata[PCTL_IGNORE_BIT];
					end
					REG_HOLD:        next_s.datapath_hold_mask  = link.wdata;
					REG_TX_OFF:      next_s.tx_output_off_mask  = link.wdata;
					REG_TX_MUTE:     next_s.tx_forced_mute_mask = link.wdata;
					REG_STAGED_CFG0: next_s.staged_cfg0         = link.wdata;
					default: begin
					end
				endcase
			end else begin
				next_s.rdata = read_reg(s, link.addr, power_class_i);
				if (link.addr == REG_FLAGS) begin
					flag_clr = s.flags;
				end
			end
		end

		// Module power state machine.
		case (s.st)
			management_init_state: begin
				if (s.cnt == CNT_ZERO) begin
					next_s.st = module_power_down_state;
					flag_set[FLAG_STATE_BIT] = 1'b1;
				end else begin
					next_s.cnt = s.cnt - 8'h01;
				end
			end
			module_power_down_state: begin
				if (!combined_power_down_condition) begin
					next_s.st  = module_powering_up_state;
					next_s.cnt = PWRUP_LOAD;
				end
			end
			module_powering_up_state: begin
				if (combined_power_down_condition) begin
					next_s.st = module_power_down_state;
					flag_set[FLAG_STATE_BIT] = 1'b1;
				end else if (s.cnt == CNT_ZERO) begin
					next_s.st = module_ready_state;
					flag_set[FLAG_STATE_BIT] = 1'b1;
				end else begin
					next_s.cnt = s.cnt - 8'h01;
				end
			end
			module_ready_state: begin
				if (combined_power_down_condition) begin
					next_s.st = module_power_down_state;
					flag_set[FLAG_STATE_BIT] = 1'b1;
				end
			end
			default: next_s.st = management_init_state;
		endcase

		// A set in the same cycle as the clearing read wins.
		next_s.flags = (s.flags & ~flag_clr) | flag_set;
		next_s.irq   = |(next_s.flags & ~next_s.mask);

		// The module reset pin restarts management initialization.
		if (!link.mod_reset_n) begin
			next_s = init_defaults(s);
			next_s.present = 1'b1;
		end
		next_s.high_power = (next_s.st == module_powering_up_state) |
		                    (next_s.st == module_ready_state);
	end

	// ********************************************************************
	// Registers.
	// ********************************************************************
	always_ff @(posedge mclk_i or negedge nrst_i) begin
		if (!nrst_i) begin
			s <= '{
				st:                    management_init_state,
				cnt:                   MGMT_INIT_LOAD,
				hw_power_down_allow:   1'b1,
				active_cfg:            DEFAULT_CFG,
				staged_cfg0:           DEFAULT_CFG,
				default:               '0
			};
		end else begin
			s <= next_s;
		end
	end

	// ********************************************************************
	// Outputs.
	// ********************************************************************
	assign link.present     = s.present;
	assign link.irq         = s.irq;
	assign link.ack         = s.ack;
	assign link.rdata       = s.rdata;
	assign module_state_o   = s.st;
	assign high_power_o     = s.high_power;
	assign active_cfg_o     = s.active_cfg;
	assign datapath_hold_o  = s.datapath_hold_mask;
	assign tx_off_o         = s.tx_output_off_mask;
	assign tx_mute_o        = s.tx_forced_mute_mask;

endmodule : module_pwr_end

// ==== module_pwr_pkg.sv ====
// Shared constants, register map and state types for the module power-up link.
package module_pwr_pkg;

	// ********************************************************************
	// Timing.
	// ********************************************************************
	localparam int CLK_PERIOD_NS = 100;
	localparam int MGMT_INIT_NS  = 2000;
	localparam int PWRUP_NS      = 5000;
	localparam int MGMT_INIT_CYC = (MGMT_INIT_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
	localparam int PWRUP_CYC     = (PWRUP_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
	typedef logic [7:0] cnt_t;
	localparam cnt_t MGMT_INIT_LOAD = cnt_t'(MGMT_INIT_CYC - 1);
	localparam cnt_t PWRUP_LOAD     = cnt_t'(PWRUP_CYC - 1);
	localparam cnt_t CNT_ZERO       = 8'h00;

	// ********************************************************************
	// Module management registers.
	// ********************************************************************
	typedef logic [7:0] byte_t;
	localparam byte_t REG_FLAGS       = 8'h00;
	localparam byte_t REG_MASK        = 8'h01;
	localparam byte_t REG_MOD_STATE   = 8'h02;
	localparam byte_t REG_POWER_CTRL  = 8'h03;
	localparam byte_t REG_POWER_CLASS = 8'h04;
	localparam byte_t REG_HOLD        = 8'h05;
	localparam byte_t REG_TX_OFF      = 8'h06;
	localparam byte_t REG_TX_MUTE     = 8'h07;
	localparam byte_t REG_DP_STATE    = 8'h08;
	localparam byte_t REG_ACTIVE_CFG  = 8'h09;
	localparam byte_t REG_STAGED_CFG0 = 8'h0A;
	localparam int    FLAG_STATE_BIT  = 0;
	localparam int    PCTL_SW_REQ_BIT = 0;
	localparam int    PCTL_ALLOW_BIT  = 1;
	localparam int    PCTL_IGNORE_BIT = 2;
	localparam byte_t BYTE_ZERO       = 8'h00;
	localparam byte_t ALL_ONES        = 8'hFF;
	localparam byte_t DP_OFF_CODE     = 8'h01;
	localparam byte_t PCTL_HOST_GO    = 8'h04;

	// ********************************************************************
	// Host control registers on Avalon-MM (word addresses).
	// ********************************************************************
	typedef logic [1:0] av_addr_t;
	localparam av_addr_t AV_CTRL   = 2'h0;
	localparam av_addr_t AV_STATUS = 2'h1;
	localparam av_addr_t AV_LIMIT  = 2'h2;
	localparam av_addr_t AV_POWER  = 2'h3;
	localparam int CTRL_START_BIT   = 0;
	localparam int CTRL_PIN_OFF_BIT = 1;
	localparam byte_t LIMIT_DEF     = 8'hFF;

	// ********************************************************************
	// States.
	// ********************************************************************
	typedef enum logic [2:0] {
		management_init_state,
		module_power_down_state,
		module_powering_up_state,
		module_ready_state
	} module_state_e;

	typedef enum logic [3:0] {
		h_idle,
		h_wait_present,
		h_wait_irq1,
		h_read_flag1,
		h_read_power,
		h_write_hold,
		h_write_tx_off,
		h_write_pctl,
		h_wait_irq2,
		h_read_flag2,
		h_done,
		h_fault
	} host_state_e;

endpackage : module_pwr_pkg

// ==== module_sw_controlled_powerup_tb.sv ====
// Testbench joining host end and module end and driving the host over Avalon.
`timescale 1ns/1ns
module module_sw_controlled_powerup_tb;
	import module_pwr_pkg::*;

	localparam byte_t CFG = 8'h5A;

	logic          mclk_i;
	logic          nrst_i;
	av_addr_t      address_i;
	logic          read_i;
	logic          write_i;
	logic [31:0]   writedata_i;
	logic [31:0]   readdata_o;
	logic          waitrequest_o;
	logic [7:0]    power_class_i;
	module_state_e module_state_o;
	logic          high_power_o;
	logic [7:0]    active_cfg_o;
	logic [7:0]    datapath_hold_o;
	logic [7:0]    tx_off_o;
	logic [7:0]    tx_mute_o;
	logic [31:0]   rd;
	int            error_cnt = 0;
	int            num_checks = 0;
	int            cyc = 0;

	mgmt_link_if u_mgmt_link_if ();

	host_pwr_end u_host_pwr_end (.mclk_i, .nrst_i, .address_i, .read_i, .write_i,
		.writedata_i, .readdata_o, .waitrequest_o, .link(u_mgmt_link_if));

	module_pwr_end #(.DEFAULT_CFG(CFG)) u_module_pwr_end (.mclk_i, .nrst_i,
		.link(u_mgmt_link_if), .power_class_i, .module_state_o, .high_power_o,
		.active_cfg_o, .datapath_hold_o, .tx_off_o, .tx_mute_o);

	module_pwr_assertions u_module_pwr_assertions (.mclk_i, .nrst_i,
		.mod_reset_n(u_mgmt_link_if.mod_reset_n),
		.hw_power_down_request_pin(u_mgmt_link_if.hw_power_down_request_pin),
		.module_select_pin(u_mgmt_link_if.module_select_pin),
		.req(u_mgmt_link_if.req), .we(u_mgmt_link_if.we), .addr(u_mgmt_link_if.addr),
		.wdata(u_mgmt_link_if.wdata), .irq(u_mgmt_link_if.irq), .ack(u_mgmt_link_if.ack));

	// ********************************************************************
	// Common tasks.
	// ********************************************************************
	task automatic tally_and_finish();
		$display("checks %0d mismatches %0d", num_checks, error_cnt);
		if (error_cnt == 0 && num_checks > 0) begin
			$display("NO MISMATCHES");
		end else begin
			$display("MISMATCHES SEEN");
		end
		$finish;
	endtask : tally_and_finish

	task automatic chk(input logic [31:0] seen, input logic [31:0] exp, input string what);
		num_checks++;
		if (seen !== exp) begin
			error_cnt++;
			$display("[FAIL] %0t %s: got %h want %h", $time, what, seen, exp);
		end
	endtask : chk

	// One Avalon transfer, held until waitrequest is sampled low.
	task automatic av_xfer(input av_addr_t a, input logic wr, input logic [31:0] wd,
		output logic [31:0] dat);
		int n;
		n = 0;
		@(posedge mclk_i);
		address_i   <= a;
		read_i      <= ~wr;
		write_i     <= wr;
		writedata_i <= wd;
		do begin
			@(posedge mclk_i);
			n++;
		end while (waitrequest_o !== 1'b0 && n < 100);
		chk(32'(waitrequest_o), 32'h0, "bus answer");
		dat = readdata_o;
		read_i  <= 1'b0;
		write_i <= 1'b0;
	endtask : av_xfer

	task automatic wait_status(input host_state_e exp);
		int n;
		n = 0;
		do begin
			av_xfer(AV_STATUS, 1'b0, 32'h0, rd);
			n++;
		end while (rd[3:0] !== exp && n < 300);
	endtask : wait_status

	// ********************************************************************
	// Scenarios.
	// ********************************************************************
	task automatic s_reset_state();
		av_xfer(AV_LIMIT, 1'b0, 32'h0, rd);
		chk(32'(rd[7:0]), 32'(LIMIT_DEF), "limit reset value");
		av_xfer(AV_STATUS, 1'b1, 32'h0000000A, rd);
		av_xfer(AV_STATUS, 1'b0, 32'h0, rd);
		chk(32'(rd[3:0]), 32'(h_idle), "status read only");
		chk(32'(u_mgmt_link_if.mod_reset_n), 32'h0, "module held in reset");
		chk(32'(module_state_o), 32'(management_init_state), "init state");
	endtask : s_reset_state

	task automatic s_full_powerup();
		int n;
		n = 0;
		av_xfer(AV_CTRL, 1'b1, 32'h1, rd);
		while (module_state_o !== module_power_down_state && n < 400) begin
			@(posedge mclk_i);
			n++;
		end
		chk(32'(module_state_o), 32'(module_power_down_state), "low power reached");
		chk(32'(datapath_hold_o), 32'h0, "hold default");
		chk(32'(tx_off_o), 32'h0, "tx off default");
		chk(32'(tx_mute_o), 32'h0, "tx mute default");
		chk(32'(active_cfg_o), 32'(CFG), "active config default");
		chk(32'(high_power_o), 32'h0, "low power at entry");
		wait_status(h_done);
		chk(32'(rd[3:0]), 32'(h_done), "sequence done");
		chk(32'(rd[7]), 32'h0, "interrupt cleared");
		chk(32'(module_state_o), 32'(module_ready_state), "ready");
		chk(32'(high_power_o), 32'h1, "high power");
		chk(32'(datapath_hold_o), 32'(ALL_ONES), "hold all ones");
		chk(32'(tx_off_o), 32'(ALL_ONES), "tx off all ones");
		av_xfer(AV_POWER, 1'b0, 32'h0, rd);
		chk(32'(rd[7:0]), 32'h05, "power class read");
	endtask : s_full_powerup

	task automatic s_power_fault();
		av_xfer(AV_LIMIT, 1'b1, 32'h1F, rd);
		power_class_i <= 8'h20;
		av_xfer(AV_CTRL, 1'b1, 32'h1, rd);
		wait_status(h_fault);
		chk(32'(rd[3:0]), 32'(h_fault), "power class above limit");
		repeat (100) @(posedge mclk_i);
		chk(32'(module_state_o), 32'(module_power_down_state), "stays low power");
		chk(32'(high_power_o), 32'h0, "no high power");
		chk(32'(datapath_hold_o), 32'h0, "hold untouched");
	endtask : s_power_fault

	task automatic s_pin_release();
		av_xfer(AV_LIMIT, 1'b1, 32'h20, rd);
		av_xfer(AV_CTRL, 1'b1, 32'h3, rd);
		wait_status(h_done);
		chk(32'(rd[3:0]), 32'(h_done), "class equal to limit");
		chk(32'(u_mgmt_link_if.hw_power_down_request_pin), 32'h0, "pin released");
		chk(32'(module_state_o), 32'(module_ready_state), "ready after release");
		av_xfer(AV_CTRL, 1'b0, 32'h0, rd);
		chk(32'(rd[CTRL_PIN_OFF_BIT]), 32'h1, "pin release bit");
	endtask : s_pin_release

	// ********************************************************************
	// Clock, timeout and main sequence.
	// ********************************************************************
	initial begin
		mclk_i = 1'b0;
		forever #50 mclk_i = ~mclk_i;
	end

	always @(posedge mclk_i) begin
		cyc <= cyc + 1;
		if (cyc == 20000) begin
			error_cnt++;
			tally_and_finish();
		end
	end

	initial begin
		nrst_i        = 1'b0;
		address_i     = AV_CTRL;
		read_i        = 1'b0;
		write_i       = 1'b0;
		writedata_i   = 32'h0;
		power_class_i = 8'h05;
		repeat (4) @(posedge mclk_i);
		nrst_i <= 1'b1;
		s_reset_state();
		s_full_powerup();
		s_power_fault();
		s_pin_release();
		tally_and_finish();
	end
endmodule : module_sw_controlled_powerup_tb
